// file: gpio_pkg.sv
package gpio_pkg;

  // ==========================================================================
  // Register byte offsets (word aligned, Wishbone 32-bit data)
  localparam logic [7:0] ADR_KP_DATA  = 8'h00;
  localparam logic [7:0] ADR_KP_DIR   = 8'h04;
  localparam logic [7:0] ADR_TC_DATA  = 8'h08;
  localparam logic [7:0] ADR_TC_DIR   = 8'h0C;
  localparam logic [7:0] ADR_FD_DATA  = 8'h10;
  localparam logic [7:0] ADR_FD_DIR   = 8'h14;
  localparam logic [7:0] ADR_FE_DATA  = 8'h18;
  localparam logic [7:0] ADR_FE_DIR   = 8'h1C;
  localparam logic [7:0] ADR_SX_DATA  = 8'h20;
  localparam logic [7:0] ADR_SV_DATA  = 8'h24;
  localparam logic [7:0] ADR_SEG_EN   = 8'h28;
  localparam logic [7:0] ADR_GP_DATA  = 8'h2C;
  localparam logic [7:0] ADR_GP_DIR   = 8'h30;
  localparam logic [7:0] ADR_INT_CTL  = 8'h34;
  localparam logic [7:0] ADR_OPTION   = 8'h38;
  localparam logic [7:0] ADR_BIT_OP   = 8'h3C;

  // ==========================================================================
  // Field positions
  localparam int INT_FLAG_BIT   = 0;
  localparam int INT_EN_BIT     = 3;
  localparam int PU_DIS_N_BIT   = 7;
  localparam int BOP_OP_LSB     = 8;
  localparam int BOP_PORT_LSB   = 10;

  // Six-bit port fixed masks
  localparam logic [5:0] GP_INPUT_ONLY = 6'h08;
  localparam logic [5:0] GP_OSC_PINS   = 6'h30;
  localparam logic [5:0] GP_SHARED_FN  = 6'h0B;

  // ==========================================================================
  // Bit-modify operations and port selects
  typedef enum logic [1:0] {
    BOP_SET   = 2'b00,
    BOP_CLR   = 2'b01,
    BOP_TGL   = 2'b10,
    BOP_KEEP  = 2'b11
  } bit_op_e;

  localparam logic [2:0] SEL_KP = 3'h0;
  localparam logic [2:0] SEL_TC = 3'h1;
  localparam logic [2:0] SEL_FD = 3'h2;
  localparam logic [2:0] SEL_FE = 3'h3;
  localparam logic [2:0] SEL_GP = 3'h4;

  // ==========================================================================
  // Pin carriers
  typedef struct packed {
    logic [5:0] gp;
    logic [7:0] sv;
    logic [7:0] sx;
    logic [7:0] fe;
    logic [7:0] fd;
    logic [7:0] tc;
    logic [7:0] kp;
  } pins_in_s;

  typedef struct packed {
    logic [5:0] gp;
    logic [7:0] fe;
    logic [7:0] fd;
    logic [7:0] tc;
    logic [7:0] kp;
  } bidir_s;

  typedef struct packed {
    pins_in_s    sync1;
    pins_in_s    sync2;
    pins_in_s    sync3;
    pins_in_s    pins_f;
    logic [7:0]  kp_lat;
    logic [7:0]  kp_dir;
    logic [7:0]  tc_lat;
    logic [7:0]  tc_dir;
    logic [7:0]  fd_lat;
    logic [7:0]  fd_dir;
    logic [7:0]  fe_lat;
    logic [7:0]  fe_dir;
    logic [5:0]  gp_lat;
    logic [5:0]  gp_dir;
    logic [15:0] seg_en;
    logic [3:0]  kp_snap;
    logic [2:0]  gp_snap;
    logic        chg_flag;
    logic        chg_en;
    logic        pu_dis_n;
    logic        ack;
    logic [31:0] dat;
    logic        wake;
  } state_s;

  // Latches cleared at reset although power-up content may be arbitrary
  localparam state_s STATE_RST = '{
    kp_dir:   8'hFF,
    tc_dir:   8'hFF,
    fd_dir:   8'hFF,
    fe_dir:   8'hFF,
    gp_dir:   6'h3F,
    seg_en:   16'hFFFF,
    pu_dis_n: 1'b1,
    default:  '0
  };

endpackage

// file: gpio_ports_change_interrupt.sv
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none

module gpio_ports_change_interrupt
(
  input  wire logic               clk_sys_i,       // 125 MHz system clock
  input  wire logic               rst_n_i,         // Synchronous reset, active low
  input  wire logic               wb_cyc_i,        // Wishbone cycle
  input  wire logic               wb_stb_i,        // Wishbone strobe
  input  wire logic               wb_we_i,         // Wishbone write enable
  input  wire logic [7:0]         wb_adr_i,        // Byte address
  input  wire logic [3:0]         wb_sel_i,        // Byte lane selects
  input  wire logic [31:0]        wb_dat_i,        // Write data
  output logic      [31:0]        wb_dat_o,        // Read data
  output logic                    wb_ack_o,        // Acknowledge
  input  wire gpio_pkg::pins_in_s pin_in_i,        // Pin levels, asynchronous
  output gpio_pkg::bidir_s        pin_out_o,       // Pin drive values
  output gpio_pkg::bidir_s        pin_oe_o,        // Pin drive enables, high drives
  output logic      [7:0]         pullup_kp_o,     // Keypad weak pull-up enables
  output logic      [5:0]         pullup_gp_o,     // Six-bit port pull-up enables
  input  wire logic [7:0]         tc_force_out_i,  // Peripheral forces third pin out
  input  wire logic [7:0]         tc_force_in_i,   // Peripheral forces third pin in
  input  wire logic [7:0]         tc_periph_dat_i, // Peripheral output data
  input  wire logic               psp_variant_i,   // Fifth dir upper bits are PSP ctl
  output logic      [3:0]         psp_ctrl_o,      // PSP control bits
  input  wire logic [5:0]         cfg_alt_func_i,  // Six-bit pins on alternate use
  input  wire logic               cfg_ext_osc_i,   // External oscillator mode
  output logic                    change_wake_o    // Wake from halt on port change
);

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] apply_op(input logic [7:0] val,
                                          input logic [1:0] op,
                                          input logic [7:0] mask);
    logic [7:0] res;
    res = val;
    case (op)
      gpio_pkg::BOP_SET: res = val | mask;
      gpio_pkg::BOP_CLR: res = val & ~mask;
      gpio_pkg::BOP_TGL: res = val ^ mask;
      default:           res = val;
    endcase
    return res;
  endfunction

  function automatic logic [7:0] lane_write(input logic [7:0] old,
                                            input logic       sel,
                                            input logic [7:0] dat);
    return sel ? dat : old;
  endfunction

  gpio_pkg::state_s state_r;
  gpio_pkg::state_s state_nxt;

  logic       req;
  logic       take;
  logic       wr_done;
  logic [7:0] adr;
  logic [7:0] tc_in_eff;
  logic [7:0] fe_in_eff;
  logic [5:0] gp_in_eff;
  logic [5:0] gp_zero;
  logic [3:0] kp_mismatch;
  logic [2:0] gp_mismatch;
  logic [7:0] gp_pins8;
  logic [7:0] bop_src;
  logic [7:0] bop_res;
  logic [31:0] rd_val;
  logic       kp_touch;
  logic       gp_touch;
  logic [53:0] s2_bits;
  logic [53:0] s3_bits;
  logic [53:0] f_bits;

  // ==========================================================================
  // Effective directions and pin masks
  always_comb
  begin
    tc_in_eff = (state_r.tc_dir | tc_force_in_i) & ~tc_force_out_i;
    fe_in_eff = psp_variant_i ? {4'hF, state_r.fe_dir[3:0]} : state_r.fe_dir;
    gp_zero   = cfg_alt_func_i | (cfg_ext_osc_i ? gpio_pkg::GP_OSC_PINS : 6'h00);
    gp_in_eff = state_r.gp_dir | gpio_pkg::GP_INPUT_ONLY
                | (cfg_ext_osc_i ? gpio_pkg::GP_OSC_PINS : 6'h00);
    gp_pins8  = {2'b00, state_r.pins_f.gp & ~gp_zero};
    // Only input pins take part in the change comparison
    kp_mismatch = (state_r.pins_f.kp[7:4] ^ state_r.kp_snap) & state_r.kp_dir[7:4];
    gp_mismatch = ({state_r.pins_f.gp[3], state_r.pins_f.gp[1:0]} ^ state_r.gp_snap)
                  & {gp_in_eff[3], gp_in_eff[1:0]}
                  & {3{state_r.chg_en}};
  end

  // ==========================================================================
  // Pin drivers and pull-ups
  always_comb
  begin
    pin_out_o.kp = state_r.kp_lat;
    pin_oe_o.kp  = ~state_r.kp_dir;
    for (int i = 0; i < 8; i++)
    begin
      pin_out_o.tc[i] = tc_force_out_i[i] ? tc_periph_dat_i[i] : state_r.tc_lat[i];
    end
    pin_oe_o.tc  = ~tc_in_eff;
    pin_out_o.fd = state_r.fd_lat;
    pin_oe_o.fd  = ~state_r.fd_dir;
    pin_out_o.fe = state_r.fe_lat;
    pin_oe_o.fe  = ~fe_in_eff;
    pin_out_o.gp = state_r.gp_lat;
    pin_oe_o.gp  = ~gp_in_eff;
    pullup_kp_o  = {8{~state_r.pu_dis_n}} & state_r.kp_dir;
    pullup_gp_o  = {6{~state_r.pu_dis_n}} & gp_in_eff & gpio_pkg::GP_SHARED_FN;
    psp_ctrl_o   = psp_variant_i ? state_r.fe_dir[7:4] : 4'h0;
  end

  // ==========================================================================
  // Bus decode and read data
  always_comb
  begin
    req     = wb_cyc_i & wb_stb_i;
    take    = req & ~state_r.ack;
    wr_done = req & state_r.ack & wb_we_i & wb_sel_i[0];
    adr     = {wb_adr_i[7:2], 2'b00};
    rd_val  = 32'h0000_0000;
    // Data reads return pin levels, never the output latches
    case (adr)
      gpio_pkg::ADR_KP_DATA: rd_val[7:0] = state_r.pins_f.kp;
      gpio_pkg::ADR_KP_DIR:  rd_val[7:0] = state_r.kp_dir;
      gpio_pkg::ADR_TC_DATA: rd_val[7:0] = state_r.pins_f.tc;
      gpio_pkg::ADR_TC_DIR:  rd_val[7:0] = state_r.tc_dir;
      gpio_pkg::ADR_FD_DATA: rd_val[7:0] = state_r.pins_f.fd;
      gpio_pkg::ADR_FD_DIR:  rd_val[7:0] = state_r.fd_dir;
      gpio_pkg::ADR_FE_DATA: rd_val[7:0] = state_r.pins_f.fe;
      gpio_pkg::ADR_FE_DIR:  rd_val[7:0] = state_r.fe_dir;
      gpio_pkg::ADR_SX_DATA: rd_val[7:0] = state_r.pins_f.sx & ~state_r.seg_en[7:0];
      gpio_pkg::ADR_SV_DATA: rd_val[7:0] = state_r.pins_f.sv & ~state_r.seg_en[15:8];
      gpio_pkg::ADR_SEG_EN:  rd_val[15:0] = state_r.seg_en;
      gpio_pkg::ADR_GP_DATA: rd_val[7:0] = gp_pins8;
      gpio_pkg::ADR_GP_DIR:  rd_val[7:0] = {2'b00, state_r.gp_dir | gpio_pkg::GP_INPUT_ONLY};
      gpio_pkg::ADR_INT_CTL:
      begin
        rd_val[gpio_pkg::INT_FLAG_BIT] = state_r.chg_flag;
        rd_val[gpio_pkg::INT_EN_BIT]   = state_r.chg_en;
      end
      gpio_pkg::ADR_OPTION:  rd_val[gpio_pkg::PU_DIS_N_BIT] = state_r.pu_dis_n;
      default:               rd_val = 32'h0000_0000;
    endcase
    // Bit-modify source is the live pin value of the chosen port
    case (wb_dat_i[gpio_pkg::BOP_PORT_LSB +: 3])
      gpio_pkg::SEL_KP: bop_src = state_r.pins_f.kp;
      gpio_pkg::SEL_TC: bop_src = state_r.pins_f.tc;
      gpio_pkg::SEL_FD: bop_src = state_r.pins_f.fd;
      gpio_pkg::SEL_FE: bop_src = state_r.pins_f.fe;
      gpio_pkg::SEL_GP: bop_src = gp_pins8;
      default:          bop_src = 8'h00;
    endcase
    bop_res  = apply_op(bop_src, wb_dat_i[gpio_pkg::BOP_OP_LSB +: 2], wb_dat_i[7:0]);
    kp_touch = take & ((adr == gpio_pkg::ADR_KP_DATA)
               | (wb_we_i & wb_sel_i[0] & (adr == gpio_pkg::ADR_BIT_OP)
                  & (wb_dat_i[gpio_pkg::BOP_PORT_LSB +: 3] == gpio_pkg::SEL_KP)));
    gp_touch = take & ((adr == gpio_pkg::ADR_GP_DATA)
               | (wb_we_i & wb_sel_i[0] & (adr == gpio_pkg::ADR_BIT_OP)
                  & (wb_dat_i[gpio_pkg::BOP_PORT_LSB +: 3] == gpio_pkg::SEL_GP)));
    s2_bits = state_r.sync2;
    s3_bits = state_r.sync3;
    f_bits  = state_r.pins_f;
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    state_nxt       = state_r;
    state_nxt.sync1 = pin_in_i;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.sync3 = state_r.sync2;
    // A pin change counts once the second and third stages agree
    state_nxt.pins_f = (s2_bits & ~(s2_bits ^ s3_bits)) | (f_bits & (s2_bits ^ s3_bits));

    // Answer one cycle after the request; read data sampled at cycle start
    state_nxt.ack = take;
    state_nxt.dat = take ? rd_val : 32'h0000_0000;

    // Snapshot refresh on any keypad or six-bit data access ends a mismatch
    if (kp_touch)
    begin
      state_nxt.kp_snap = state_r.pins_f.kp[7:4];
    end
    if (gp_touch)
    begin
      state_nxt.gp_snap = {state_r.pins_f.gp[3], state_r.pins_f.gp[1:0]};
    end

    // Writes take effect on the edge where the master sees ack
    if (wr_done)
    begin
      case (adr)
        gpio_pkg::ADR_KP_DATA: state_nxt.kp_lat = wb_dat_i[7:0];
        gpio_pkg::ADR_KP_DIR:  state_nxt.kp_dir = wb_dat_i[7:0];
        gpio_pkg::ADR_TC_DATA: state_nxt.tc_lat = wb_dat_i[7:0];
        gpio_pkg::ADR_TC_DIR:  state_nxt.tc_dir = wb_dat_i[7:0];
        gpio_pkg::ADR_FD_DATA: state_nxt.fd_lat = wb_dat_i[7:0];
        gpio_pkg::ADR_FD_DIR:  state_nxt.fd_dir = wb_dat_i[7:0];
        gpio_pkg::ADR_FE_DATA: state_nxt.fe_lat = wb_dat_i[7:0];
        gpio_pkg::ADR_FE_DIR:  state_nxt.fe_dir = wb_dat_i[7:0];
        gpio_pkg::ADR_SEG_EN:
        begin
          state_nxt.seg_en[7:0]  = wb_dat_i[7:0];
          state_nxt.seg_en[15:8] = lane_write(state_r.seg_en[15:8], wb_sel_i[1],
                                              wb_dat_i[15:8]);
        end
        gpio_pkg::ADR_GP_DATA: state_nxt.gp_lat = wb_dat_i[5:0];
        gpio_pkg::ADR_GP_DIR:  state_nxt.gp_dir = wb_dat_i[5:0];
        gpio_pkg::ADR_INT_CTL: state_nxt.chg_en = wb_dat_i[gpio_pkg::INT_EN_BIT];
        gpio_pkg::ADR_OPTION:  state_nxt.pu_dis_n = wb_dat_i[gpio_pkg::PU_DIS_N_BIT];
        gpio_pkg::ADR_BIT_OP:
        begin
          // Whole latch rewritten from pins, so inputs land in the latch too
          case (wb_dat_i[gpio_pkg::BOP_PORT_LSB +: 3])
            gpio_pkg::SEL_KP: state_nxt.kp_lat = bop_res;
            gpio_pkg::SEL_TC: state_nxt.tc_lat = bop_res;
            gpio_pkg::SEL_FD: state_nxt.fd_lat = bop_res;
            gpio_pkg::SEL_FE: state_nxt.fe_lat = bop_res;
            gpio_pkg::SEL_GP: state_nxt.gp_lat = bop_res[5:0];
            default:          state_nxt.kp_lat = state_r.kp_lat;
          endcase
        end
        default:               state_nxt.kp_lat = state_r.kp_lat;
      endcase
    end

    // Software clears by writing zero; a present mismatch wins over the clear
    if (wr_done && adr == gpio_pkg::ADR_INT_CTL && !wb_dat_i[gpio_pkg::INT_FLAG_BIT])
    begin
      state_nxt.chg_flag = 1'b0;
    end
    if (|kp_mismatch || |gp_mismatch)
    begin
      state_nxt.chg_flag = 1'b1;
    end
    state_nxt.wake = state_r.chg_flag & state_r.chg_en;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= gpio_pkg::STATE_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign wb_ack_o      = state_r.ack;
  assign wb_dat_o      = state_r.dat;
  assign change_wake_o = state_r.wake;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence seq_kp_write;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_ack_o
      && (adr == gpio_pkg::ADR_KP_DATA);
  endsequence

  sequence seq_kp_read_taken;
    take && !wb_we_i && (adr == gpio_pkg::ADR_KP_DATA);
  endsequence

  a_ack_next_cycle: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
  a_kp_write_latch: assert property (seq_kp_write |=> pin_out_o.kp == $past(wb_dat_i[7:0]))
    else $error("keypad latch not written at ack edge");
  a_snapshot_on_read: assert property (seq_kp_read_taken |=>
      state_r.kp_snap == $past(state_r.pins_f.kp[7:4]))
    else $error("snapshot not refreshed on keypad read");
  a_outputs_excluded: assert property ((!state_r.chg_flag && gp_mismatch == 3'h0
      && ((state_r.pins_f.kp[7:4] ^ state_r.kp_snap) & state_r.kp_dir[7:4]) == 4'h0)
      |=> !state_r.chg_flag)
    else $error("output pin took part in change compare");
  a_flag_stays_set: assert property ((|kp_mismatch) |=> state_r.chg_flag)
    else $error("flag not set during mismatch");
  a_wake_follows: assert property ((state_r.chg_flag && state_r.chg_en) |=> change_wake_o)
    else $error("wake not raised by change flag");
  a_gp3_never_out: assert property (!pin_oe_o.gp[3])
    else $error("input only pin driven");
  a_gp_dir_reset: assert property (!$past(rst_n_i) |-> state_r.gp_dir == 6'h3F)
    else $error("six-bit direction not all ones after reset");
  a_gp_upper_zero: assert property ((take && adr == gpio_pkg::ADR_GP_DATA) |=>
      wb_dat_o[7:6] == 2'b00)
    else $error("unimplemented bits not zero");
  a_pullup_off_out: assert property ((pullup_kp_o & pin_oe_o.kp) == 8'h00)
    else $error("pull-up on while output");
  a_tc_forced_out: assert property ((tc_force_out_i & ~pin_oe_o.tc) == 8'h00)
    else $error("forced output not driven");
  a_flag_clears: assert property ((wr_done && adr == gpio_pkg::ADR_INT_CTL
      && !wb_dat_i[gpio_pkg::INT_FLAG_BIT] && kp_mismatch == 4'h0 && gp_mismatch == 3'h0)
      |=> !state_r.chg_flag)
    else $error("change flag not cleared without mismatch");
  a_gp_change_sense: assert property ((state_r.chg_en && gp_in_eff[3]
      && (state_r.pins_f.gp[3] != state_r.gp_snap[2])) |=> state_r.chg_flag)
    else $error("six-bit pin change did not set flag");
  a_alt_reads_zero: assert property ((take && adr == gpio_pkg::ADR_GP_DATA) |=>
      (wb_dat_o[5:0] & $past(gp_zero)) == 6'h00)
    else $error("alternate function pin did not read zero");
  a_osc_pins_free: assert property (cfg_ext_osc_i |->
      (pin_oe_o.gp & gpio_pkg::GP_OSC_PINS) == 6'h00)
    else $error("oscillator pins still driven");
  a_gp3_dir_one: assert property ((take && adr == gpio_pkg::ADR_GP_DIR) |=>
      wb_dat_o[3])
    else $error("input only direction bit read zero");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_pullup_reset: assert property (!$past(rst_n_i) |-> state_r.pu_dis_n)
    else $error("pull-ups not off after reset");

endmodule

`default_nettype wire

// file: gpio_pin_model.sv
`timescale 1ns/1ns
`default_nettype none

module gpio_pin_model
(
  input  wire logic               clk_sys_i, // Bench clock
  input  wire gpio_pkg::bidir_s   drv_val_i, // Block drive values
  input  wire gpio_pkg::bidir_s   drv_en_i,  // Block drive enables
  input  wire logic [7:0]         pu_kp_i,   // Keypad pull-ups
  input  wire logic [5:0]         pu_gp_i,   // Six-bit pull-ups
  input  wire gpio_pkg::pins_in_s ext_val_i, // Outside driver values
  input  wire gpio_pkg::pins_in_s ext_en_i,  // Outside driver enables
  output var gpio_pkg::pins_in_s  lvl_o      // Resolved pin levels
);
  logic flt_r = 1'b0;

  // Floating pins wander every cycle so a stale level is never trusted
  always_ff @(posedge clk_sys_i)
    flt_r <= ~flt_r;

  function automatic logic [7:0] res(input logic [7:0] dv, de, ev, ee, pu);
    return (de & dv) | (~de & ee & ev) | (~de & ~ee & (pu | {8{flt_r}}));
  endfunction

  always_comb
  begin
    lvl_o.kp = res(drv_val_i.kp, drv_en_i.kp, ext_val_i.kp, ext_en_i.kp, pu_kp_i);
    lvl_o.tc = res(drv_val_i.tc, drv_en_i.tc, ext_val_i.tc, ext_en_i.tc, 8'h00);
    lvl_o.fd = res(drv_val_i.fd, drv_en_i.fd, ext_val_i.fd, ext_en_i.fd, 8'h00);
    lvl_o.fe = res(drv_val_i.fe, drv_en_i.fe, ext_val_i.fe, ext_en_i.fe, 8'h00);
    lvl_o.sx = res(8'h00, 8'h00, ext_val_i.sx, ext_en_i.sx, 8'h00);
    lvl_o.sv = res(8'h00, 8'h00, ext_val_i.sv, ext_en_i.sv, 8'h00);
    lvl_o.gp = 6'(res({2'b0, drv_val_i.gp}, {2'b0, drv_en_i.gp}, {2'b0, ext_val_i.gp},
                     {2'b0, ext_en_i.gp}, {2'b0, pu_gp_i}));
  end
endmodule

`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic               clk_sys_i = 1'b0;
  logic               rst_n_i = 1'b0;
  logic               cyc = 1'b0;
  logic               we = 1'b0;
  logic [3:0]         sel = 4'h0;
  logic [3:0]         lanes = 4'hF;
  logic [7:0]         adr = 8'h00;
  logic [31:0]        wdat = 32'h0000_0000;
  logic [31:0]        rdat;
  logic [31:0]        rd;
  logic               ack;
  gpio_pkg::pins_in_s ev = '0;
  gpio_pkg::pins_in_s ee = '0;
  gpio_pkg::pins_in_s lvl;
  gpio_pkg::bidir_s   po;
  gpio_pkg::bidir_s   oe;
  logic [7:0]         pu_kp;
  logic [7:0]         f_out = 8'h00;
  logic [7:0]         f_in = 8'h00;
  logic [7:0]         p_dat = 8'h00;
  logic [5:0]         pu_gp;
  logic [5:0]         alt = 6'h00;
  logic               psp = 1'b0;
  logic               osc = 1'b0;
  logic               wake;
  logic [3:0]         psp_ctl;
  int                 n_errors = 0;
  int                 total_checks = 0;
  int                 cyc_n = 0;
  logic [7:0]         v;
  logic [7:0]         e;
  logic [7:0]         m;
  logic [7:0]         x;

  always #4 clk_sys_i = ~clk_sys_i;

  gpio_ports_change_interrupt dut_u
  (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pin_in_i(lvl), .pin_out_o(po), .pin_oe_o(oe), .pullup_kp_o(pu_kp),
    .pullup_gp_o(pu_gp), .tc_force_out_i(f_out), .tc_force_in_i(f_in),
    .tc_periph_dat_i(p_dat), .psp_variant_i(psp), .psp_ctrl_o(psp_ctl),
    .cfg_alt_func_i(alt), .cfg_ext_osc_i(osc), .change_wake_o(wake)
  );

  gpio_pin_model pm_u
  (
    .clk_sys_i(clk_sys_i), .drv_val_i(po), .drv_en_i(oe), .pu_kp_i(pu_kp),
    .pu_gp_i(pu_gp), .ext_val_i(ev), .ext_en_i(ee), .lvl_o(lvl)
  );

  task automatic test_done();
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] xp);
    total_checks++;
    if (s !== xp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, xp, s);
    end
  endtask

  // Classic single cycle; holds the request until ack, only the bench timeout ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= dt;
    do
    begin
      @(posedge clk_sys_i);
    end
    while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  function automatic logic [7:0] bop(input int op, input logic [7:0] p, mk);
    case (op)
      0: return p | mk;
      1: return p & ~mk;
      2: return p ^ mk;
      default: return p;
    endcase
  endfunction

  always @(posedge clk_sys_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      n_errors++;
      test_done();
    end
  end

  initial
  begin
    void'($urandom(32'h4004_de3a));
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    tick(1);
    chk("oe reset", oe, 0);
    chk("pull-up reset", pu_kp, 0);
    bus(0, gpio_pkg::ADR_GP_DIR, 0);
    chk("gp dir reset", rd, 32'h3F);
    ev.sx <= 8'hA5;
    ev.sv <= 8'h3C;
    ee.sx <= 8'hFF;
    ee.sv <= 8'hFF;
    tick(6);
    bus(0, gpio_pkg::ADR_SX_DATA, 0);
    chk("sx segment", rd, 0);
    bus(1, gpio_pkg::ADR_SEG_EN, 0);
    bus(0, gpio_pkg::ADR_SV_DATA, 0);
    chk("sv pins", rd, 32'h3C);
    repeat (8)
    begin
      v = 8'($urandom);
      m = 8'($urandom);
      e = 8'($urandom);
      x = ~m;
      ev.kp <= e;
      ee.kp <= m;
      bus(1, gpio_pkg::ADR_KP_DATA, {24'h0, v});
      bus(1, gpio_pkg::ADR_KP_DIR, {24'h0, m});
      tick(6);
      chk("kp oe", oe.kp, x);
      chk("kp out", po.kp & x, v & x);
      bus(0, gpio_pkg::ADR_KP_DATA, 0);
      chk("kp pins", rd, (v & x) | (e & m));
    end
    v = 8'($urandom);
    ev.gp <= ~v[5:0];
    ee.gp <= 6'h08;
    bus(1, gpio_pkg::ADR_GP_DATA, {24'h0, v});
    bus(1, gpio_pkg::ADR_GP_DIR, 0);
    bus(0, gpio_pkg::ADR_GP_DIR, 0);
    chk("gp dir", rd, 32'h08);
    tick(6);
    chk("gp oe", oe.gp, 6'h37);
    chk("gp out", po.gp & 6'h37, v[5:0] & 6'h37);
    x = {2'b0, (v[5:0] & 6'h37) | (~v[5:0] & 6'h08)};
    bus(0, gpio_pkg::ADR_GP_DATA, 0);
    chk("gp pins", rd, x);
    alt <= 6'h03;
    osc <= 1'b1;
    tick(6);
    chk("osc oe", oe.gp & 6'h30, 0);
    bus(0, gpio_pkg::ADR_GP_DATA, 0);
    chk("gp alt", rd, x & 8'h0C);
    alt <= 6'h00;
    osc <= 1'b0;
    bus(1, gpio_pkg::ADR_TC_DIR, 32'h0F);
    for (int k = 0; k < 4; k++)
    begin
      v = 8'($urandom);
      e = 8'($urandom);
      m = 8'($urandom);
      ev.tc <= e;
      ee.tc <= 8'h0F;
      bus(1, gpio_pkg::ADR_TC_DATA, {24'h0, v});
      tick(6);
      bus(1, gpio_pkg::ADR_BIT_OP, {19'h0, gpio_pkg::SEL_TC, 2'(k), m});
      tick(1);
      chk("bit op", po.tc, bop(k, {v[7:4], e[3:0]}, m));
    end
    bus(1, gpio_pkg::ADR_TC_DIR, 32'hFE);
    f_out <= 8'h01;
    f_in <= 8'h02;
    p_dat <= 8'h01;
    tick(2);
    chk("force oe", oe.tc, 8'h01);
    chk("force out", po.tc[0], 1'b1);
    f_out <= 8'h00;
    f_in <= 8'h00;
    psp <= 1'b1;
    bus(1, gpio_pkg::ADR_FE_DIR, 32'h50);
    tick(1);
    chk("psp ctrl", psp_ctl, 4'h5);
    chk("psp oe", oe.fe, 8'h0F);
    psp <= 1'b0;
    tick(1);
    chk("fe oe", oe.fe, 8'hAF);
    bus(1, gpio_pkg::ADR_OPTION, 0);
    ev.kp <= 8'h00;
    ee.kp <= 8'hF0;
    bus(1, gpio_pkg::ADR_KP_DIR, 32'hF0);
    tick(6);
    chk("pull-up on", pu_kp, 8'hF0);
    chk("gp pull-up", pu_gp, 6'h08);
    bus(0, gpio_pkg::ADR_KP_DATA, 0);
    bus(1, gpio_pkg::ADR_INT_CTL, 0);
    bus(0, gpio_pkg::ADR_INT_CTL, 0);
    chk("flag idle", rd, 0);
    ev.kp <= 8'h20;
    tick(8);
    bus(1, gpio_pkg::ADR_INT_CTL, 0);
    bus(0, gpio_pkg::ADR_INT_CTL, 0);
    chk("flag held", rd, 1);
    bus(0, gpio_pkg::ADR_KP_DATA, 0);
    bus(1, gpio_pkg::ADR_INT_CTL, 0);
    bus(0, gpio_pkg::ADR_INT_CTL, 0);
    chk("flag cleared", rd, 0);
    bus(1, gpio_pkg::ADR_KP_DATA, 32'h10);
    bus(1, gpio_pkg::ADR_KP_DIR, 32'hEF);
    tick(8);
    bus(1, gpio_pkg::ADR_INT_CTL, 0);
    bus(0, gpio_pkg::ADR_INT_CTL, 0);
    chk("output excluded", rd, 0);
    bus(1, gpio_pkg::ADR_INT_CTL, 32'h08);
    ev.kp <= 8'h00;
    tick(8);
    chk("wake", wake, 1'b1);
    bus(0, gpio_pkg::ADR_KP_DATA, 0);
    bus(1, gpio_pkg::ADR_INT_CTL, 32'h08);
    tick(3);
    chk("wake off", wake, 1'b0);
    lanes = 4'h0;
    bus(1, gpio_pkg::ADR_KP_DATA, 32'hEF);
    lanes = 4'hF;
    tick(1);
    chk("latch held", po.kp, 8'h10);
    ev.gp[3] <= ~ev.gp[3];
    tick(8);
    bus(0, gpio_pkg::ADR_INT_CTL, 0);
    chk("gp change", rd, 32'h09);
    bus(0, 8'h40, 0);
    chk("unmapped", rd, 0);
    test_done();
  end
endmodule

`default_nettype wire
